// ---- include/lsx_pkg.sv ----
// Package for the load/store execution unit: opcode classes, modes, cycle counts.
// Assumes an 8-bit core with 16-bit data and program addresses.
package lsx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int LSX_DW = 8;
  localparam int LSX_AW = 16;
  localparam int LSX_RW = 5;
  localparam int LSX_IOW = 6;
  localparam int LSX_QW = 6;

  // ----------------------------------------------------------------
  // Cycle counts per instruction class
  // ----------------------------------------------------------------
  localparam logic [1:0] LSX_CYC_DATA = 2'h2;
  localparam logic [1:0] LSX_CYC_PROG = 2'h3;
  localparam logic [1:0] LSX_CYC_ONE  = 2'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [LSX_AW-1:0] LSX_PTR_RST = 16'h0000;
  localparam logic [LSX_AW-1:0] LSX_SP_RST  = 16'h08ff;
  localparam logic [LSX_RW-1:0] LSX_REG_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    LSX_OP_NOP,
    LSX_OP_INDIRECT_LOAD,
    LSX_OP_INDIRECT_STORE,
    LSX_OP_DISPLACEMENT_LOAD,
    LSX_OP_DISPLACEMENT_STORE,
    LSX_OP_DIRECT_LOAD,
    LSX_OP_DIRECT_STORE,
    LSX_OP_PROGRAM_MEMORY_READ,
    LSX_OP_IO_IN,
    LSX_OP_IO_OUT,
    LSX_OP_PUSH,
    LSX_OP_POP,
    LSX_OP_SLEEP,
    LSX_OP_WATCHDOG_RESTART,
    LSX_OP_BREAK
  } lsx_op_t;

  typedef enum logic [1:0] {
    LSX_AM_PLAIN,
    LSX_AM_POST_INC,
    LSX_AM_PRE_DEC
  } lsx_mode_t;

  // Pointer pair select: 0 first, 1 second, 2 third
  localparam logic [1:0] LSX_PTR_FIRST  = 2'h0;
  localparam logic [1:0] LSX_PTR_SECOND = 2'h1;
  localparam logic [1:0] LSX_PTR_THIRD  = 2'h2;

endpackage

// ---- src/lsx_dest_reg.sv ----
// Result latch: holds the byte and target register index of a load.
// Assumes the register file samples wb_valid as a one-cycle pulse.
`timescale 1ns/10ps
module lsx_dest_reg
  import lsx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              load,
  input  wire logic [LSX_RW-1:0] idx_in,
  input  wire logic [LSX_DW-1:0] data_in,
  output logic                   wb_valid,
  output logic      [LSX_RW-1:0] wb_idx,
  output logic      [LSX_DW-1:0] wb_data
);

  // ----------------------------------------------------------------
  // Write-back latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_valid <= 1'b0;
      wb_idx   <= LSX_REG_ZERO;
      wb_data  <= 8'h00;
    end else begin
      wb_valid <= load;
      if (load) begin
        wb_idx  <= idx_in;
        wb_data <= data_in;
      end
    end
  end

endmodule

// ---- src/lsx_exec.sv ----
// Load/store execution unit for an 8-bit core: data, program and I/O moves.
// Assumes data memory answers reads one cycle after the address, program
// memory two cycles after, and I/O reads combinationally.
//
// Overview of operation
// RULE1: Post-increment load reads, then pointer plus one
// RULE2: Pre-decrement load decrements pointer, then reads
// RULE3: Displacement load uses pointer plus offset, unchanged
// RULE4: Post-increment store writes, then pointer plus one
// RULE5: Pre-decrement store decrements pointer, then writes
// RULE6: Displacement store uses pointer plus offset
// RULE7: Direct load from instruction address, two cycles
// RULE8: Direct store to instruction address, two cycles
// RULE9: Program read via third pointer, three cycles
// RULE10: I/O in and out take one cycle
// RULE11: Push stores register on stack, two cycles
// RULE12: Pop loads register from stack, two cycles
// RULE13: Sleep one cycle, signals sleep logic
// RULE14: Watchdog restart one cycle, signals watchdog
// RULE15: Break only signals the debug facility
// RULE16: Pointer updates visible next instruction; flags untouched
`timescale 1ns/10ps
module lsx_exec
  import lsx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              issue,
  input  wire lsx_op_t           op,
  input  wire lsx_mode_t         mode,
  input  wire logic [1:0]        ptr_sel,
  input  wire logic [LSX_QW-1:0] disp,
  input  wire logic [LSX_AW-1:0] direct_addr,
  input  wire logic [LSX_IOW-1:0] io_addr,
  input  wire logic [LSX_RW-1:0] reg_idx,
  input  wire logic [LSX_DW-1:0] src_data,
  input  wire logic [LSX_DW-1:0] dmem_rdata,
  input  wire logic [LSX_DW-1:0] pmem_rdata,
  input  wire logic [LSX_DW-1:0] io_rdata,
  output logic                   busy,
  output logic                   done,
  output logic      [LSX_AW-1:0] dmem_addr,
  output logic                   dmem_re,
  output logic                   dmem_we,
  output logic      [LSX_DW-1:0] dmem_wdata,
  output logic      [LSX_AW-1:0] pmem_addr,
  output logic                   pmem_re,
  output logic      [LSX_IOW-1:0] io_addr_out,
  output logic                   io_re,
  output logic                   io_we,
  output logic      [LSX_DW-1:0] io_wdata,
  output logic                   wb_valid,
  output logic      [LSX_RW-1:0] wb_idx,
  output logic      [LSX_DW-1:0] wb_data,
  output logic                   sleep_req,
  output logic                   watchdog_restart,
  output logic                   break_req,
  output logic                   flags_we,
  output logic      [LSX_AW-1:0] ptr_first,
  output logic      [LSX_AW-1:0] ptr_second,
  output logic      [LSX_AW-1:0] ptr_third,
  output logic      [LSX_AW-1:0] sp
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [LSX_AW-1:0] step(input logic [LSX_AW-1:0] a, input logic up);
    step = up ? LSX_AW'(a + 16'h0001) : LSX_AW'(a - 16'h0001);
  endfunction

  function automatic logic [1:0] cycles_of(input lsx_op_t o);
    unique case (o)
      LSX_OP_PROGRAM_MEMORY_READ: cycles_of = LSX_CYC_PROG;
      LSX_OP_NOP, LSX_OP_IO_IN, LSX_OP_IO_OUT, LSX_OP_SLEEP,
      LSX_OP_WATCHDOG_RESTART, LSX_OP_BREAK: cycles_of = LSX_CYC_ONE;
      default: cycles_of = LSX_CYC_DATA;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Instruction state
  // ----------------------------------------------------------------
  lsx_op_t           cur_op;
  logic [LSX_RW-1:0] cur_reg;
  logic [LSX_AW-1:0] cur_addr;
  logic [1:0]        cur_sel;
  logic              cur_ptr_upd;
  logic [LSX_AW-1:0] cur_ptr_new;
  logic [1:0]        remain;
  logic [LSX_AW-1:0] sel_ptr;
  logic [LSX_AW-1:0] next_addr;
  logic              ptr_we;
  logic              sp_we;
  logic [LSX_AW-1:0] sp_wdata;
  logic              ld_fire;
  logic [LSX_DW-1:0] ld_data;
  logic              last;

  lsx_ptr_file u_ptr (
    .clk        (clk),
    .rst        (rst),
    .ptr_we     (ptr_we),
    .ptr_sel    (cur_sel),
    .ptr_wdata  (cur_ptr_new),
    .sp_we      (sp_we),
    .sp_wdata   (sp_wdata),
    .ptr_first  (ptr_first),
    .ptr_second (ptr_second),
    .ptr_third  (ptr_third),
    .sp         (sp)
  );

  always_comb begin
    unique case (ptr_sel)
      LSX_PTR_FIRST:  sel_ptr = ptr_first;
      LSX_PTR_SECOND: sel_ptr = ptr_second;
      default:        sel_ptr = ptr_third;
    endcase
  end

  // Effective address at issue
  always_comb begin
    unique case (op)
      LSX_OP_INDIRECT_LOAD, LSX_OP_INDIRECT_STORE:
        next_addr = (mode == LSX_AM_PRE_DEC) ? step(sel_ptr, 1'b0) : sel_ptr; // [RULE2] [RULE5]
      LSX_OP_DISPLACEMENT_LOAD, LSX_OP_DISPLACEMENT_STORE:
        next_addr = LSX_AW'(sel_ptr + {10'h000, disp}); // [RULE3] [RULE6]
      LSX_OP_DIRECT_LOAD, LSX_OP_DIRECT_STORE:
        next_addr = direct_addr; // [RULE7] [RULE8]
      LSX_OP_PROGRAM_MEMORY_READ:
        next_addr = ptr_third; // [RULE9]
      LSX_OP_PUSH:
        next_addr = sp; // [RULE11]
      LSX_OP_POP:
        next_addr = step(sp, 1'b1); // [RULE12]
      default:
        next_addr = direct_addr;
    endcase
  end

  assign last   = busy && remain == 2'h1;
  assign ptr_we = last && cur_ptr_upd; // [RULE16]
  assign sp_we  = last && (cur_op == LSX_OP_PUSH || cur_op == LSX_OP_POP);
  assign sp_wdata = (cur_op == LSX_OP_PUSH) ? step(sp, 1'b0) : cur_addr;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      busy        <= 1'b0;
      remain      <= 2'h0;
      cur_op      <= LSX_OP_NOP;
      cur_reg     <= LSX_REG_ZERO;
      cur_addr    <= LSX_PTR_RST;
      cur_sel     <= LSX_PTR_FIRST;
      cur_ptr_upd <= 1'b0;
      cur_ptr_new <= LSX_PTR_RST;
    end else if (issue && !busy && cycles_of(op) != LSX_CYC_ONE) begin
      busy    <= 1'b1;
      remain  <= 2'(cycles_of(op) - 2'h1); // [RULE1] [RULE9]
      cur_op  <= op;
      cur_reg <= (op == LSX_OP_PROGRAM_MEMORY_READ && mode == LSX_AM_PLAIN &&
                  reg_idx == LSX_REG_ZERO) ? LSX_REG_ZERO : reg_idx; // [RULE9]
      cur_addr <= next_addr;
      cur_sel  <= (op == LSX_OP_PROGRAM_MEMORY_READ) ? LSX_PTR_THIRD : ptr_sel;
      cur_ptr_upd <= ((op == LSX_OP_INDIRECT_LOAD || op == LSX_OP_INDIRECT_STORE ||
                       op == LSX_OP_PROGRAM_MEMORY_READ) && mode != LSX_AM_PLAIN);
      cur_ptr_new <= (mode == LSX_AM_POST_INC) ? step(next_addr, 1'b1)
                                               : next_addr; // [RULE1] [RULE4]
    end else if (busy) begin
      remain <= 2'(remain - 2'h1);
      busy   <= remain != 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= last || (issue && !busy && cycles_of(op) == LSX_CYC_ONE); // [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // Memory strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dmem_addr  <= LSX_PTR_RST;
      dmem_re    <= 1'b0;
      dmem_we    <= 1'b0;
      dmem_wdata <= 8'h00;
    end else begin
      dmem_re <= 1'b0;
      dmem_we <= 1'b0;
      if (issue && !busy) begin
        dmem_addr  <= next_addr;
        dmem_wdata <= src_data;
        unique case (op)
          LSX_OP_INDIRECT_LOAD, LSX_OP_DISPLACEMENT_LOAD, LSX_OP_DIRECT_LOAD,
          LSX_OP_POP: dmem_re <= 1'b1; // [RULE1] [RULE7] [RULE12]
          LSX_OP_INDIRECT_STORE, LSX_OP_DISPLACEMENT_STORE, LSX_OP_DIRECT_STORE,
          LSX_OP_PUSH: dmem_we <= 1'b1; // [RULE4] [RULE8] [RULE11]
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pmem_addr <= LSX_PTR_RST;
      pmem_re   <= 1'b0;
    end else begin
      pmem_re <= issue && !busy && op == LSX_OP_PROGRAM_MEMORY_READ;
      if (issue && !busy) begin
        pmem_addr <= next_addr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_addr_out <= 6'h00;
      io_re       <= 1'b0;
      io_we       <= 1'b0;
      io_wdata    <= 8'h00;
    end else begin
      io_re <= issue && !busy && op == LSX_OP_IO_IN; // [RULE10]
      io_we <= issue && !busy && op == LSX_OP_IO_OUT; // [RULE10]
      if (issue && !busy) begin
        io_addr_out <= io_addr;
        io_wdata    <= src_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core control pulses; flags are never written here
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_req        <= 1'b0;
      watchdog_restart <= 1'b0;
      break_req        <= 1'b0;
      flags_we         <= 1'b0;
    end else begin
      sleep_req        <= issue && !busy && op == LSX_OP_SLEEP; // [RULE13]
      watchdog_restart <= issue && !busy && op == LSX_OP_WATCHDOG_RESTART; // [RULE14]
      break_req        <= issue && !busy && op == LSX_OP_BREAK; // [RULE15]
      flags_we         <= 1'b0; // [RULE16]
    end
  end

  // ----------------------------------------------------------------
  // Write-back
  // ----------------------------------------------------------------
  // I/O input is read combinationally at issue to hold the one-cycle count
  always_comb begin
    ld_fire = 1'b0;
    ld_data = dmem_rdata;
    if (issue && !busy && op == LSX_OP_IO_IN) begin
      ld_fire = 1'b1; // [RULE10]
      ld_data = io_rdata;
    end else if (last) begin
      unique case (cur_op)
        LSX_OP_PROGRAM_MEMORY_READ: begin
          ld_fire = 1'b1; // [RULE9]
          ld_data = pmem_rdata;
        end
        LSX_OP_INDIRECT_LOAD, LSX_OP_DISPLACEMENT_LOAD, LSX_OP_DIRECT_LOAD,
        LSX_OP_POP: ld_fire = 1'b1; // [RULE2] [RULE12]
        default: ;
      endcase
    end
  end

  lsx_dest_reg u_wb (
    .clk      (clk),
    .rst      (rst),
    .load     (ld_fire),
    .idx_in   ((issue && !busy) ? reg_idx : cur_reg),
    .data_in  (ld_data),
    .wb_valid (wb_valid),
    .wb_idx   (wb_idx),
    .wb_data  (wb_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_load_two_cycles: assert property ( // [RULE1]
    issue && !busy && op == LSX_OP_INDIRECT_LOAD |-> ##2 (done && wb_valid))
    else $error("indirect load did not finish in two cycles");
  a_prog_three: assert property ( // [RULE9]
    issue && !busy && op == LSX_OP_PROGRAM_MEMORY_READ |-> ##1 busy[*2] ##1 done)
    else $error("program read not three cycles");
  a_store_strobe: assert property ( // [RULE8]
    issue && !busy && op == LSX_OP_DIRECT_STORE |=> dmem_we && !dmem_re)
    else $error("store strobe missing");
  a_io_one: assert property ( // [RULE10]
    issue && !busy && op == LSX_OP_IO_OUT |=> io_we && done && !busy)
    else $error("io out not one cycle");
  a_sleep_pulse: assert property ( // [RULE13]
    issue && !busy && op == LSX_OP_SLEEP |=> sleep_req && done)
    else $error("sleep not signalled");
  a_wd_pulse: assert property ( // [RULE14]
    issue && !busy && op == LSX_OP_WATCHDOG_RESTART |=> watchdog_restart && !flags_we)
    else $error("watchdog restart not signalled");
  a_ptr_post: assert property ( // [RULE16]
    ptr_we && cur_sel == LSX_PTR_THIRD |=> ptr_third == $past(cur_ptr_new))
    else $error("pointer not updated");
  a_predec_addr: assert property ( // [RULE2]
    issue && !busy && op == LSX_OP_INDIRECT_LOAD && mode == LSX_AM_PRE_DEC &&
    ptr_sel == LSX_PTR_FIRST |=> dmem_addr == LSX_AW'($past(ptr_first) - 16'h0001))
    else $error("pre-decrement address wrong");
  a_disp_keep: assert property ( // [RULE3]
    issue && !busy && op == LSX_OP_DISPLACEMENT_LOAD |-> ##2 $stable(ptr_second))
    else $error("displacement changed pointer");
  a_pop_two: assert property ( // [RULE12]
    issue && !busy && op == LSX_OP_POP |-> ##2 (done && wb_valid))
    else $error("pop not two cycles");
  a_no_flags: assert property (!flags_we) // [RULE16]
    else $error("flags written");

  c_load: cover property (issue && !busy && op == LSX_OP_INDIRECT_LOAD ##2 done);
  c_prog: cover property (issue && !busy && op == LSX_OP_PROGRAM_MEMORY_READ);
  c_push: cover property (issue && !busy && op == LSX_OP_PUSH);
  c_io:   cover property (io_we);

endmodule

// ---- src/lsx_ptr_file.sv ----
// Pointer pair file: three 16-bit pointers plus the stack pointer.
// Assumes two update ports, pointer and stack pointer, driven by the sequencer on the same clock.
`timescale 1ns/10ps
module lsx_ptr_file
  import lsx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ptr_we,
  input  wire logic [1:0]        ptr_sel,
  input  wire logic [LSX_AW-1:0] ptr_wdata,
  input  wire logic              sp_we,
  input  wire logic [LSX_AW-1:0] sp_wdata,
  output logic      [LSX_AW-1:0] ptr_first,
  output logic      [LSX_AW-1:0] ptr_second,
  output logic      [LSX_AW-1:0] ptr_third,
  output logic      [LSX_AW-1:0] sp
);

  // ----------------------------------------------------------------
  // Pointer storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_first  <= LSX_PTR_RST;
      ptr_second <= LSX_PTR_RST;
      ptr_third  <= LSX_PTR_RST;
    end else if (ptr_we) begin
      // Written on the last cycle so the next instruction sees it
      unique case (ptr_sel)
        LSX_PTR_FIRST:  ptr_first  <= ptr_wdata;
        LSX_PTR_SECOND: ptr_second <= ptr_wdata;
        LSX_PTR_THIRD:  ptr_third  <= ptr_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sp <= LSX_SP_RST;
    end else if (sp_we) begin
      sp <= sp_wdata;
    end
  end

endmodule

// ---- testbench/load_store_execution_unit_tb.sv ----
// Self-checking bench for the load/store execution unit.
// Assumes lsx_mem_model answers memory and I/O reads behind the unit.
`timescale 1ns/10ps
module load_store_execution_unit_tb import lsx_pkg::*;;
  logic               clk = 1'b0, rst = 1'b1, issue = 1'b0;
  lsx_op_t            op = LSX_OP_NOP;
  lsx_mode_t          mode = LSX_AM_PLAIN;
  logic [1:0]         ptr_sel = 2'h0;
  logic [LSX_QW-1:0]  disp = 6'h00;
  logic [LSX_AW-1:0]  direct_addr = 16'h0000;
  logic [LSX_IOW-1:0] io_addr = 6'h00, io_addr_out;
  logic [LSX_RW-1:0]  reg_idx = 5'h00, wb_idx;
  logic [LSX_DW-1:0]  src_data = 8'h00, dmem_rdata, pmem_rdata, io_rdata;
  logic [LSX_DW-1:0]  dmem_wdata, io_wdata, wb_data;
  logic               busy, done, dmem_re, dmem_we, pmem_re, io_re, io_we, wb_valid;
  logic               sleep_req, watchdog_restart, break_req, flags_we;
  logic [LSX_AW-1:0]  dmem_addr, pmem_addr, ptr_first, ptr_second, ptr_third, sp;
  logic [15:0]        ptr_m [3];
  logic [15:0]        sp_m = LSX_SP_RST;
  logic [31:0]        seed = 32'h0afe702d;
  int                 errors = 0, compares = 0;

  always #25 clk = ~clk;

  lsx_exec u_lsx_exec (.clk, .rst, .issue, .op, .mode, .ptr_sel, .disp, .direct_addr,
    .io_addr, .reg_idx, .src_data, .dmem_rdata, .pmem_rdata, .io_rdata, .busy, .done,
    .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata, .pmem_addr, .pmem_re, .io_addr_out,
    .io_re, .io_we, .io_wdata, .wb_valid, .wb_idx, .wb_data, .sleep_req,
    .watchdog_restart, .break_req, .flags_we, .ptr_first, .ptr_second, .ptr_third, .sp);

  lsx_mem_model u_lsx_mem_model (.clk, .rst, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata,
    .pmem_addr, .pmem_re, .io_addr, .dmem_rdata, .pmem_rdata, .io_rdata);

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One instruction; intr issues a sleep while busy, which must be ignored
  task automatic run_op(input lsx_op_t o, input lsx_mode_t m, input logic [1:0] s,
                        input logic [5:0] q, input logic [15:0] k, input logic [5:0] a,
                        input logic [4:0] r, input logic [7:0] d, input logic intr);
    logic [15:0] p, ea, np, nsp, ra, wa, pa;
    logic [7:0]  ev, wd, iod;
    logic [1:0]  cyc;
    logic        ld, st, rd, pr, loose, sw, sr, sg, so, ss, sd, sb, si;
    int          n;
    pr = (o == LSX_OP_PROGRAM_MEMORY_READ);
    if (pr)
      s = LSX_PTR_THIRD;
    p = ptr_m[s];
    np = p;
    ea = p;
    nsp = sp_m;
    cyc = pr ? LSX_CYC_PROG : LSX_CYC_DATA;
    case (o)
      LSX_OP_INDIRECT_LOAD, LSX_OP_INDIRECT_STORE, LSX_OP_PROGRAM_MEMORY_READ: begin
        if (m == LSX_AM_POST_INC)
          np = p + 16'h0001;
        if (m == LSX_AM_PRE_DEC)
          np = p - 16'h0001;
        if (m == LSX_AM_PRE_DEC)
          ea = np;
      end
      LSX_OP_DISPLACEMENT_LOAD, LSX_OP_DISPLACEMENT_STORE: ea = p + {10'h000, q};
      LSX_OP_DIRECT_LOAD, LSX_OP_DIRECT_STORE: ea = k;
      LSX_OP_PUSH: begin
        ea = sp_m;
        nsp = sp_m - 16'h0001;
      end
      LSX_OP_POP: begin
        nsp = sp_m + 16'h0001;
        ea = nsp;
      end
      default: cyc = LSX_CYC_ONE;
    endcase
    // A one-cycle op is free again at once, so a late request would be taken
    if (cyc == LSX_CYC_ONE)
      intr = 1'b0;
    loose = o inside {LSX_OP_NOP, LSX_OP_BREAK};
    rd = o inside {LSX_OP_INDIRECT_LOAD, LSX_OP_DISPLACEMENT_LOAD, LSX_OP_DIRECT_LOAD,
                   LSX_OP_POP};
    st = o inside {LSX_OP_INDIRECT_STORE, LSX_OP_DISPLACEMENT_STORE, LSX_OP_DIRECT_STORE,
                   LSX_OP_PUSH};
    ld = rd || pr || o == LSX_OP_IO_IN;
    ev = pr ? u_lsx_mem_model.pmem[ea] : u_lsx_mem_model.dmem[ea];
    if (o == LSX_OP_IO_IN)
      ev = {2'h0, a} ^ 8'h96;
    @(posedge clk);
    issue <= 1'b1;
    op <= o;
    mode <= m;
    ptr_sel <= s;
    disp <= q;
    direct_addr <= k;
    io_addr <= a;
    reg_idx <= r;
    src_data <= d;
    {sw, sr, sg, so, ss, sd, sb, si} = 8'h00;
    for (n = 1; n <= 8; n++) begin
      @(posedge clk);
      // First edge takes the op; a sleep raised there meets busy
      issue <= intr && n == 1;
      if (intr)
        op <= LSX_OP_SLEEP;
      #1;
      chk("flags_we", 0, flags_we);
      if (dmem_re) begin
        sr = 1'b1;
        ra = dmem_addr;
      end
      if (dmem_we) begin
        sw = 1'b1;
        wa = dmem_addr;
        wd = dmem_wdata;
      end
      if (pmem_re) begin
        sg = 1'b1;
        pa = pmem_addr;
      end
      if (io_we) begin
        so = 1'b1;
        iod = io_wdata;
      end
      ss |= sleep_req;
      sd |= watchdog_restart;
      sb |= break_req;
      si |= io_re;
      if (done || (loose && n == 3))
        break;
    end
    if (!done && !loose) begin
      chk("done in time", 1, 0);
      results();
    end
    if (!loose) chk("cycles", cyc, n);
    chk("wb_valid", ld, wb_valid);
    if (ld) chk("wb_data", ev, wb_data);
    if (ld) chk("wb_idx", r, wb_idx);
    chk("dmem_re", rd, sr);
    if (rd) chk("read address", ea, ra);
    chk("dmem_we", st, sw);
    if (st) chk("write address", ea, wa);
    if (st) chk("dmem_wdata", d, wd);
    chk("pmem_re", pr, sg);
    if (pr) chk("pmem_addr", ea, pa);
    chk("io_we", o == LSX_OP_IO_OUT, so);
    chk("io_re", o == LSX_OP_IO_IN, si);
    if (so) chk("io write", {a, d}, {io_addr_out, iod});
    chk("sleep_req", o == LSX_OP_SLEEP, ss);
    chk("watchdog_restart", o == LSX_OP_WATCHDOG_RESTART, sd);
    chk("break_req", o == LSX_OP_BREAK, sb);
    ptr_m[s] = np;
    sp_m = nsp;
    chk("ptr_first", ptr_m[0], ptr_first);
    chk("ptr_second", ptr_m[1], ptr_second);
    chk("ptr_third", ptr_m[2], ptr_third);
    chk("sp", sp_m, sp);
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    lsx_op_t     ro;
    lsx_mode_t   rm;
    logic [1:0]  rs;
    logic [31:0] x;
    ptr_m = '{default: 16'h0000};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("sp after reset", LSX_SP_RST, sp);
    chk("busy after reset", 0, busy);
    // Pointer wraps below zero
    run_op(LSX_OP_INDIRECT_LOAD, LSX_AM_PRE_DEC, 2'h0, 6'h00, 16'h0000, 6'h00, 5'h03, 8'h00, 1'b0);
    for (int i = 0; i < 3; i++) begin
      run_op(LSX_OP_INDIRECT_STORE, LSX_AM_POST_INC, 2'(i), 6'h00, 16'h0000, 6'h00, 5'h01, 8'ha0 + 8'(i), 1'b0);
      run_op(LSX_OP_INDIRECT_LOAD, LSX_AM_PRE_DEC, 2'(i), 6'h00, 16'h0000, 6'h00, 5'h02, 8'h00, 1'b1);
      run_op(LSX_OP_INDIRECT_STORE, LSX_AM_PRE_DEC, 2'(i), 6'h00, 16'h0000, 6'h00, 5'h04, 8'h5c, 1'b0);
      run_op(LSX_OP_INDIRECT_LOAD, LSX_AM_POST_INC, 2'(i), 6'h00, 16'h0000, 6'h00, 5'h05, 8'h00, 1'b0);
    end
    for (int i = 1; i < 3; i++) begin
      run_op(LSX_OP_DISPLACEMENT_STORE, LSX_AM_PLAIN, 2'(i), 6'h3f, 16'h0000, 6'h00, 5'h06, 8'he7, 1'b0);
      run_op(LSX_OP_DISPLACEMENT_LOAD, LSX_AM_PLAIN, 2'(i), 6'h3f, 16'h0000, 6'h00, 5'h07, 8'h00, 1'b0);
    end
    run_op(LSX_OP_DIRECT_STORE, LSX_AM_PLAIN, 2'h0, 6'h00, 16'hffff, 6'h00, 5'h08, 8'h5a, 1'b0);
    run_op(LSX_OP_DIRECT_LOAD, LSX_AM_PLAIN, 2'h0, 6'h00, 16'hffff, 6'h00, 5'h1f, 8'h00, 1'b0);
    run_op(LSX_OP_PUSH, LSX_AM_PLAIN, 2'h0, 6'h00, 16'h0000, 6'h00, 5'h09, 8'hc3, 1'b0);
    run_op(LSX_OP_PUSH, LSX_AM_PLAIN, 2'h0, 6'h00, 16'h0000, 6'h00, 5'h0a, 8'h3c, 1'b0);
    run_op(LSX_OP_POP, LSX_AM_PLAIN, 2'h0, 6'h00, 16'h0000, 6'h00, 5'h0b, 8'h00, 1'b0);
    run_op(LSX_OP_POP, LSX_AM_PLAIN, 2'h0, 6'h00, 16'h0000, 6'h00, 5'h0c, 8'h00, 1'b0);
    run_op(LSX_OP_PROGRAM_MEMORY_READ, LSX_AM_PLAIN, 2'h2, 6'h00, 16'h0000, 6'h00, LSX_REG_ZERO, 8'h00, 1'b0);
    run_op(LSX_OP_PROGRAM_MEMORY_READ, LSX_AM_POST_INC, 2'h2, 6'h00, 16'h0000, 6'h00, 5'h0d, 8'h00, 1'b1);
    run_op(LSX_OP_IO_IN, LSX_AM_PLAIN, 2'h0, 6'h00, 16'h0000, 6'h3f, 5'h0e, 8'h00, 1'b0);
    run_op(LSX_OP_IO_OUT, LSX_AM_PLAIN, 2'h0, 6'h00, 16'h0000, 6'h2a, 5'h0f, 8'h81, 1'b0);
    for (int i = 12; i < 15; i++)
      run_op(lsx_op_t'(i), LSX_AM_PLAIN, 2'h0, 6'h00, 16'h0000, 6'h00, 5'h00, 8'h00, 1'b0);
    // Random mix; pointer modes only where they mean something
    for (int i = 0; i < 120; i++) begin
      ro = lsx_op_t'(rnd() % 15);
      rm = LSX_AM_PLAIN;
      rs = 2'(rnd() % 3);
      if (ro inside {LSX_OP_INDIRECT_LOAD, LSX_OP_INDIRECT_STORE})
        rm = lsx_mode_t'(rnd() % 3);
      if (ro == LSX_OP_PROGRAM_MEMORY_READ)
        rm = lsx_mode_t'(rnd() % 2);
      if (ro inside {LSX_OP_DISPLACEMENT_LOAD, LSX_OP_DISPLACEMENT_STORE})
        rs = 2'(1 + rnd() % 2);
      x = rnd();
      run_op(ro, rm, rs, x[5:0], x[31:16], x[11:6], x[16:12], x[31:24], x[0]);
    end
    results();
  end
endmodule

// ---- testbench/lsx_mem_model.sv ----
// Behavioural data memory, program memory and I/O space facing the unit.
// Assumes the unit's clock; addresses hold through each read window.
`timescale 1ns/10ps
module lsx_mem_model
  import lsx_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [LSX_AW-1:0]  dmem_addr,
  input  wire logic               dmem_re,
  input  wire logic               dmem_we,
  input  wire logic [LSX_DW-1:0]  dmem_wdata,
  input  wire logic [LSX_AW-1:0]  pmem_addr,
  input  wire logic               pmem_re,
  input  wire logic [LSX_IOW-1:0] io_addr,
  output logic      [LSX_DW-1:0]  dmem_rdata,
  output logic      [LSX_DW-1:0]  pmem_rdata,
  output logic      [LSX_DW-1:0]  io_rdata
);
  logic [LSX_DW-1:0] dmem [0:65535];
  logic [LSX_DW-1:0] pmem [0:65535];
  logic              d_win = 1'b0;
  logic              p_win1 = 1'b0;
  logic              p_win2 = 1'b0;
  logic [LSX_DW-1:0] d_last = 8'h00;
  logic [LSX_DW-1:0] p_last = 8'h00;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      dmem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3c;
      pmem[i] = 8'(i) + 8'(i >> 8) + 8'ha5;
    end
  end

  // -------------------------------------------------------------
  // Read windows
  // -------------------------------------------------------------
  // Outside its window read data flips, so a late sample is caught
  always @(posedge clk) begin
    if (dmem_we)
      dmem[dmem_addr] <= dmem_wdata;
    d_win  <= !rst && dmem_re;
    p_win1 <= !rst && pmem_re;
    p_win2 <= p_win1;
    d_last <= dmem_rdata;
    p_last <= pmem_rdata;
  end

  assign dmem_rdata = (dmem_re || d_win) ? dmem[dmem_addr] : ~d_last;
  assign pmem_rdata = (pmem_re || p_win1 || p_win2) ? pmem[pmem_addr] : ~p_last;
  assign io_rdata   = {2'h0, io_addr} ^ 8'h96;
endmodule
